// >>> hw/lctg_defines.svh
`ifndef LCTG_DEFINES_SVH
`define LCTG_DEFINES_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define LCTG_CLK_PS            50000
`define LCTG_CYC_FLOOR_PS      6000

// ----------------------------------------
// Limits in picoseconds and cycle minimums
// ----------------------------------------
`define LCTG_MRW_CYC           3
`define LCTG_MRR_CYC           2
`define LCTG_SR_LOW_PS         15000
`define LCTG_SR_LOW_CYC        3
`define LCTG_SR_EXIT_ADD_PS    10000
`define LCTG_SR_EXIT_CYC       2
`define LCTG_RFCAB_PS          130000
`define LCTG_PD_EXIT_PS        7500
`define LCTG_PD_EXIT_CYC       2
`define LCTG_RTP_PS            7500
`define LCTG_RTP_CYC           2
`define LCTG_WTR_FAST_PS       7500
`define LCTG_WTR_SLOW_PS       10000
`define LCTG_WTR_CYC           2
`define LCTG_RRD_PS            10000
`define LCTG_RRD_CYC           2
`define LCTG_DERATE_PS         1875
`define LCTG_DPD_US            500
`define LCTG_BOOT_MIN_PS       18000
`define LCTG_TEMP_MR_ADDR      8'h04

`endif

// >>> hw/lctg_down_counter.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Guard counter: busy until count elapses
// ----------------------------------------
module lctg_down_counter #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  initial begin
    if (W < 2) $error("lctg_down_counter: W too small");
  end

  // Load value of N blocks the following N cycles
  assign cnt_d = load ? load_val : ((cnt_q != '0) ? cnt_q - W'(1) : cnt_q);
  assign busy  = (cnt_q != '0);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : lctg_down_counter

`default_nettype wire

// >>> hw/lctg_guard.sv
// Behaviour
// (RULE1) After a mode register write, wait 3 cycles before any command.
// (RULE2) After a mode register read, wait 2 cycles before any command.
// (RULE3) In self refresh keep clock enable low max(15 ns, 3 cycles).
// (RULE4) After self refresh exit wait refresh cycle plus 10 ns, min 2 cycles.
// (RULE5) After power-down exit wait max(7.5 ns, 2 cycles).
// (RULE6) Read to precharge same bank at least max(7.5 ns, 2 cycles).
// (RULE7) Write data end to read: 7.5 ns fast, 10 ns slow grades, min 2.
// (RULE8) Activates to different banks spaced max(10 ns, 2 cycles).
// (RULE9) Deep power-down held at least 500 us before exit.
// (RULE10) Where ns and cycle limits both exist, take the longer.
// (RULE11) Cycle minimums apply only when the clock period exceeds 6 ns.
// (RULE12) Before configuration clock runs 10-55 MHz, period at least 18 ns.
// (RULE13) Device loads mode register defaults on a reset write.
// (RULE14) Temperature register asks derating: add 1.875 ns to core limits. Code derates only the activate spacing (RULE8).
// (RULE15) Each ns limit becomes rounded-up cycles held by a down-counter.
`timescale 1ns/1ps
`default_nettype none
`include "lctg_defines.svh"

module lctg_guard #(
  parameter int unsigned CLK_PS     = `LCTG_CLK_PS,
  parameter int unsigned DPD_CYCLES = (`LCTG_DPD_US * 1000000) / `LCTG_CLK_PS,
  parameter bit          SLOW_GRADE = 1'b1,
  parameter int          NBANK      = 8,
  parameter int          CW         = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire lctg_pkg::lctg_cmd_t req_cmd,
  input  wire logic [2:0]          req_bank,
  input  wire logic [7:0]          req_mr_addr,
  input  wire logic                mr_rdata_valid,
  input  wire logic [7:0]          mr_rdata,
  input  wire logic                configured,
  output logic                     cmd_valid,
  output lctg_pkg::lctg_cmd_t      cmd_out,
  output logic [2:0]               cmd_bank,
  output logic [7:0]               cmd_mr_addr,
  output logic                     cke,
  output logic                     derate_active,
  output logic                     boot_clock_ok
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  initial begin
    if (NBANK != 8) $error("lctg_guard: bank field serves eight banks");
    if (DPD_CYCLES >= (1 << CW)) $error("lctg_guard: CW too narrow for deep sleep");
    if (CLK_PS == 0) $error("lctg_guard: zero clock period");
  end

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam bit USE_MIN = (CLK_PS > `LCTG_CYC_FLOOR_PS); // RULE11
  localparam int unsigned WTR_PS = SLOW_GRADE ? `LCTG_WTR_SLOW_PS : `LCTG_WTR_FAST_PS; // RULE7

  // RULE10 RULE15
  localparam logic [31:0] MRW_N = `LCTG_MRW_CYC; // RULE1
  localparam logic [31:0] MRR_N = `LCTG_MRR_CYC; // RULE2
  localparam logic [31:0] SRL_N = lctg_pkg::lctg_cycles(`LCTG_SR_LOW_PS, CLK_PS,
                                    `LCTG_SR_LOW_CYC, USE_MIN); // RULE3
  localparam logic [31:0] SRX_N = lctg_pkg::lctg_cycles(`LCTG_RFCAB_PS + `LCTG_SR_EXIT_ADD_PS,
                                    CLK_PS, `LCTG_SR_EXIT_CYC, USE_MIN); // RULE4
  localparam logic [31:0] PDX_N = lctg_pkg::lctg_cycles(`LCTG_PD_EXIT_PS, CLK_PS,
                                    `LCTG_PD_EXIT_CYC, USE_MIN); // RULE5
  localparam logic [31:0] RTP_N = lctg_pkg::lctg_cycles(`LCTG_RTP_PS, CLK_PS,
                                    `LCTG_RTP_CYC, USE_MIN); // RULE6
  localparam logic [31:0] WTR_N = lctg_pkg::lctg_cycles(WTR_PS, CLK_PS,
                                    `LCTG_WTR_CYC, USE_MIN); // RULE7
  localparam logic [31:0] RRD_N = lctg_pkg::lctg_cycles(`LCTG_RRD_PS, CLK_PS,
                                    `LCTG_RRD_CYC, USE_MIN); // RULE8
  localparam logic [31:0] RRDD_N = lctg_pkg::lctg_cycles(`LCTG_RRD_PS + `LCTG_DERATE_PS,
                                    CLK_PS, `LCTG_RRD_CYC, USE_MIN); // RULE14

  // ----------------------------------------
  // Issue decode
  // ----------------------------------------
  wire logic is_mrw  = (req_cmd == lctg_pkg::LCTG_CMD_MRW);
  wire logic is_mrr  = (req_cmd == lctg_pkg::LCTG_CMD_MRR);
  wire logic is_act  = (req_cmd == lctg_pkg::LCTG_CMD_ACT);
  wire logic is_rd   = (req_cmd == lctg_pkg::LCTG_CMD_RD);
  wire logic is_wr   = (req_cmd == lctg_pkg::LCTG_CMD_WR);
  wire logic is_pre  = (req_cmd == lctg_pkg::LCTG_CMD_PRE);
  wire logic is_srx  = (req_cmd == lctg_pkg::LCTG_CMD_SR_EXIT);
  wire logic is_pdx  = (req_cmd == lctg_pkg::LCTG_CMD_PD_EXIT);
  wire logic is_dpdx = (req_cmd == lctg_pkg::LCTG_CMD_DPD_EXIT);
  wire logic is_sre  = (req_cmd == lctg_pkg::LCTG_CMD_SR_ENTER);
  wire logic is_dpde = (req_cmd == lctg_pkg::LCTG_CMD_DPD_ENTER);
  wire logic is_pde  = (req_cmd == lctg_pkg::LCTG_CMD_PD_ENTER);
  wire logic is_exit = is_srx | is_pdx | is_dpdx;

  lctg_pkg::lctg_pwr_t pwr_state;
  logic                issue;

  logic any_busy;
  logic sr_low_busy;
  logic dpd_busy;
  logic wtr_busy;
  logic rrd_busy;
  logic [NBANK-1:0] rtp_busy;
  logic [7:0]       last_act_bank_q;
  logic             act_seen_q;
  logic             derate_q;
  logic             boot_ok_q;
  logic             cfg_m_q;
  logic             cfg_q;

  // Command-to-command gap after mode register access and self refresh and power-down exits
  logic [CW-1:0] gap_val;
  assign gap_val = is_mrw ? CW'(MRW_N - 32'd1) :          // RULE1
                   is_mrr ? CW'(MRR_N - 32'd1) :          // RULE2
                   is_srx ? CW'(SRX_N) :                  // RULE4
                   is_pdx ? CW'(PDX_N) :                  // RULE5
                   '0;

  // Per-state legality of the requested command
  wire logic state_ok =
    (pwr_state == lctg_pkg::LCTG_PWR_SELF_REF)    ? is_srx :
    (pwr_state == lctg_pkg::LCTG_PWR_POWER_DOWN)  ? is_pdx :
    (pwr_state == lctg_pkg::LCTG_PWR_DEEP_SLEEP)  ? is_dpdx :
    !is_exit;

  wire logic rtp_hit = is_pre && rtp_busy[req_bank];                       // RULE6
  wire logic rrd_hit = is_act && rrd_busy && act_seen_q
                       && (last_act_bank_q[2:0] != req_bank);               // RULE8
  wire logic wtr_hit = is_rd && wtr_busy;                                   // RULE7
  wire logic srl_hit = is_srx && sr_low_busy;                               // RULE3
  wire logic dpd_hit = is_dpdx && dpd_busy;                                 // RULE9
  wire logic boot_hit = !boot_ok_q;                                         // RULE12

  assign req_ready = state_ok && !any_busy && !rtp_hit && !rrd_hit && !wtr_hit
                     && !srl_hit && !dpd_hit && !boot_hit;
  assign issue = req_valid && req_ready;

  // ----------------------------------------
  // Guard counters
  // ----------------------------------------
  lctg_down_counter #(.W(CW)) u_gap (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .load     (issue && (gap_val != '0)),
    .load_val (gap_val),
    .busy     (any_busy)
  );

  lctg_down_counter #(.W(CW)) u_srl (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .load     (issue && is_sre),
    .load_val (CW'(SRL_N - 32'd1)),
    .busy     (sr_low_busy)
  ); // RULE3

  lctg_down_counter #(.W(CW)) u_dpd (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .load     (issue && is_dpde),
    .load_val (CW'(DPD_CYCLES)),
    .busy     (dpd_busy)
  ); // RULE9

  lctg_down_counter #(.W(CW)) u_wtr (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .load     (issue && is_wr),
    .load_val (CW'(WTR_N)),
    .busy     (wtr_busy)
  ); // RULE7

  lctg_down_counter #(.W(CW)) u_rrd (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .load     (issue && is_act),
    .load_val (derate_q ? CW'(RRDD_N - 32'd1) : CW'(RRD_N - 32'd1)),
    .busy     (rrd_busy)
  ); // RULE8 RULE14

  for (genvar b = 0; b < NBANK; b++) begin : g_rtp
    lctg_down_counter #(.W(CW)) u_rtp (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .load     (issue && is_rd && (req_bank == 3'(b))),
      .load_val (CW'(RTP_N - 32'd1)),
      .busy     (rtp_busy[b])
    ); // RULE6
  end

  lctg_power_tracker u_pwr (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .issue     (issue),
    .cmd       (req_cmd),
    .pwr_state (pwr_state),
    .cke       (cke)
  ); // RULE3

  // ----------------------------------------
  // Derating and boot clock tracking
  // ----------------------------------------
  // Refresh-rate code above 3 on the temperature register means derate
  logic mrr_temp_q;
  wire logic temp_rsp = mr_rdata_valid && mrr_temp_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_act_bank_q <= 8'h00;
      act_seen_q      <= 1'b0;
      derate_q        <= 1'b0;
      mrr_temp_q      <= 1'b0;
      cfg_m_q         <= 1'b0;
      cfg_q           <= 1'b0;
      boot_ok_q       <= 1'b0;
    end else begin
      cfg_m_q    <= configured;
      cfg_q      <= cfg_m_q;
      boot_ok_q  <= cfg_q | (CLK_PS >= `LCTG_BOOT_MIN_PS); // RULE12
      if (issue && is_act) begin
        last_act_bank_q <= {5'h00, req_bank};
        act_seen_q      <= 1'b1;
      end
      if (issue && is_mrr) mrr_temp_q <= (req_mr_addr == `LCTG_TEMP_MR_ADDR);
      else if (mr_rdata_valid) mrr_temp_q <= 1'b0;
      if (temp_rsp) derate_q <= (mr_rdata[2:0] > 3'h3); // RULE14
    end
  end

  // ----------------------------------------
  // Command outputs, registered
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_valid   <= 1'b0;
      cmd_out     <= lctg_pkg::LCTG_CMD_NOP;
      cmd_bank    <= 3'h0;
      cmd_mr_addr <= 8'h00;
    end else begin
      cmd_valid   <= issue;
      cmd_out     <= issue ? req_cmd : lctg_pkg::LCTG_CMD_NOP;
      cmd_bank    <= issue ? req_bank : cmd_bank;
      cmd_mr_addr <= issue ? req_mr_addr : cmd_mr_addr;
    end
  end

  assign derate_active = derate_q;
  assign boot_clock_ok = boot_ok_q;

endmodule : lctg_guard

`default_nettype wire

// >>> hw/lctg_pkg.sv
package lctg_pkg;

  typedef enum logic [3:0] {
    LCTG_CMD_NOP,
    LCTG_CMD_MRW,
    LCTG_CMD_MRR,
    LCTG_CMD_ACT,
    LCTG_CMD_RD,
    LCTG_CMD_WR,
    LCTG_CMD_PRE,
    LCTG_CMD_SR_ENTER,
    LCTG_CMD_SR_EXIT,
    LCTG_CMD_PD_ENTER,
    LCTG_CMD_PD_EXIT,
    LCTG_CMD_DPD_ENTER,
    LCTG_CMD_DPD_EXIT
  } lctg_cmd_t;

  typedef enum logic [1:0] {
    LCTG_PWR_ACTIVE,
    LCTG_PWR_SELF_REF,
    LCTG_PWR_POWER_DOWN,
    LCTG_PWR_DEEP_SLEEP
  } lctg_pwr_t;

  // Ceiling of picoseconds over the clock period, at least one cycle, and never below min cycles when use_min is set
  function automatic logic [31:0] lctg_cycles(input int unsigned ps, input int unsigned period_ps,
                                              input int unsigned min_cyc, input bit use_min);
    int unsigned c;
    c = (ps + period_ps - 1) / period_ps;
    if (c == 0) c = 1;
    if (use_min && (c < min_cyc)) c = min_cyc;
    return 32'(c);
  endfunction : lctg_cycles

endpackage : lctg_pkg

// >>> hw/lctg_power_tracker.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Power state of the memory as seen by the controller
// ----------------------------------------
module lctg_power_tracker (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               issue,
  input  wire lctg_pkg::lctg_cmd_t cmd,
  output lctg_pkg::lctg_pwr_t     pwr_state,
  output logic                    cke
);

  lctg_pkg::lctg_pwr_t pwr_q;
  lctg_pkg::lctg_pwr_t pwr_d;

  always_comb begin
    pwr_d = pwr_q;
    if (issue) begin
      case (cmd)
        lctg_pkg::LCTG_CMD_SR_ENTER:  pwr_d = lctg_pkg::LCTG_PWR_SELF_REF;
        lctg_pkg::LCTG_CMD_PD_ENTER:  pwr_d = lctg_pkg::LCTG_PWR_POWER_DOWN;
        lctg_pkg::LCTG_CMD_DPD_ENTER: pwr_d = lctg_pkg::LCTG_PWR_DEEP_SLEEP;
        lctg_pkg::LCTG_CMD_SR_EXIT,
        lctg_pkg::LCTG_CMD_PD_EXIT,
        lctg_pkg::LCTG_CMD_DPD_EXIT:  pwr_d = lctg_pkg::LCTG_PWR_ACTIVE;
        default:                      pwr_d = pwr_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwr_q <= lctg_pkg::LCTG_PWR_ACTIVE;
      cke   <= 1'b1;
    end else begin
      pwr_q <= pwr_d;
      cke   <= (pwr_d == lctg_pkg::LCTG_PWR_ACTIVE);
    end
  end

  assign pwr_state = pwr_q;

endmodule : lctg_power_tracker

`default_nettype wire

// >>> test/lctg_guard_props.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Command spacing checks at the guard ports
// ----------------------------------------
module lctg_guard_props #(
  parameter int unsigned DPD_CYCLES = 20
) (
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                req_valid,
  input wire logic                req_ready,
  input wire lctg_pkg::lctg_cmd_t req_cmd,
  input wire logic [7:0]          mr_rdata,
  input wire logic                mr_rdata_valid,
  input wire logic                cmd_valid,
  input wire lctg_pkg::lctg_cmd_t cmd_out,
  input wire logic [2:0]          cmd_bank,
  input wire logic                derate_active,
  input wire logic                boot_clock_ok
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  wire mrw = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_MRW);
  wire mrr = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_MRR);
  wire act = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_ACT);
  wire rd  = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_RD);
  wire wr  = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_WR);
  wire pre = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_PRE);
  wire sre = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_SR_ENTER);
  wire srx = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_SR_EXIT);
  wire pdx = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_PD_EXIT);
  wire dpe = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_DPD_ENTER);
  wire dpx = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_DPD_EXIT);

  // Saturates so a long stay never wraps
  int unsigned dpd_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) dpd_q <= 0;
    else if (dpe) dpd_q <= 1;
    else if ((dpd_q != 0) && (dpd_q < DPD_CYCLES)) dpd_q <= dpd_q + 1;
  end

  a_mrw_gap: assert property (mrw |=> !cmd_valid [*2])
    else $error("mode write followed too soon");
  a_mrr_gap: assert property (mrr |=> !cmd_valid)
    else $error("mode read followed too soon");
  a_sr_low: assert property (sre |=> !srx [*2])
    else $error("self refresh left too soon");
  a_sr_exit: assert property (srx |=> !cmd_valid [*2])
    else $error("command too soon after self refresh exit");
  a_pd_exit: assert property (pdx |=> !cmd_valid)
    else $error("command too soon after power-down exit");
  a_rd_pre: assert property (rd |=> !(pre && (cmd_bank == $past(cmd_bank))))
    else $error("precharge too soon after read");
  a_wr_rd: assert property (wr |=> !rd)
    else $error("read too soon after write");
  a_act_act: assert property (act |=> !(act && (cmd_bank != $past(cmd_bank))))
    else $error("activates too close");
  a_dpd_hold: assert property (dpx |-> (dpd_q >= DPD_CYCLES))
    else $error("deep sleep left too soon");
  a_issue_next: assert property (req_valid && req_ready |=> cmd_valid && (cmd_out == $past(req_cmd)))
    else $error("accepted request not issued next cycle");
  a_boot_ok: assert property (!$past(sys_rst) |-> boot_clock_ok)
    else $error("boot clock flag low");
  a_derate_on: assert property (mr_rdata_valid && (mr_rdata[2:0] > 3'h3) |-> ##[1:3] derate_active)
    else $error("derating not raised");

  c_mrw: cover property (mrw);
  c_dpd: cover property (dpx);
  c_derate: cover property ($rose(derate_active));
endmodule : lctg_guard_props

bind lctg_guard lctg_guard_props #(.DPD_CYCLES(DPD_CYCLES)) lctg_guard_props_inst (
  .sys_clk, .sys_rst, .req_valid, .req_ready, .req_cmd, .mr_rdata, .mr_rdata_valid,
  .cmd_valid, .cmd_out, .cmd_bank, .derate_active, .boot_clock_ok
);

`default_nettype wire

// >>> test/lctg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lctg_defines.svh"

// ----------------------------------------
// Memory side: answers mode reads
// ----------------------------------------
module lctg_mem_model #(
  parameter logic [7:0] RESET_MR_ADDR = 8'h3F,
  parameter logic [2:0] TEMP_DEFAULT  = 3'h3
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                cmd_valid,
  input  wire lctg_pkg::lctg_cmd_t cmd_out,
  input  wire logic [7:0]          cmd_mr_addr,
  input  wire logic                temp_load,
  input  wire logic [2:0]          temp_val,
  output logic                     mr_rdata_valid,
  output logic [7:0]               mr_rdata
);
  logic [2:0] temp_q;
  logic [7:0] last_q;
  wire is_mrr = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_MRR);
  wire is_rst = cmd_valid && (cmd_out == lctg_pkg::LCTG_CMD_MRW) && (cmd_mr_addr == RESET_MR_ADDR);
  wire [7:0] rd_val = (cmd_mr_addr == `LCTG_TEMP_MR_ADDR) ? {5'h00, temp_q} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || is_rst) temp_q <= TEMP_DEFAULT;
    else if (temp_load) temp_q <= temp_val;
  end

  always_ff @(posedge sys_clk) begin
    mr_rdata_valid <= !sys_rst && is_mrr;
    if (sys_rst) last_q <= 8'h00;
    else if (is_mrr) last_q <= rd_val;
  end

  // Stale data is inverted so a late sample cannot pass
  assign mr_rdata = mr_rdata_valid ? last_q : ~last_q;
endmodule : lctg_mem_model

`default_nettype wire

// >>> test/test_lpddr_command_timing_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "lctg_defines.svh"

module test_lpddr_command_timing_guard;
  logic                sys_clk, sys_rst, req_valid, req_ready, configured, temp_load;
  logic                mr_rdata_valid, cmd_valid, cke, derate_active, boot_clock_ok;
  lctg_pkg::lctg_cmd_t req_cmd, cmd_out;
  logic [2:0]          req_bank, cmd_bank, temp_val;
  logic [7:0]          req_mr_addr, mr_rdata, cmd_mr_addr;
  int                  n_fail, cmp_count, cyc;
  int                  t[13];

  lctg_guard #(.DPD_CYCLES(20), .CW(16)) lctg_guard_inst (
    .sys_clk, .sys_rst, .req_valid, .req_ready, .req_cmd, .req_bank, .req_mr_addr,
    .mr_rdata_valid, .mr_rdata, .configured, .cmd_valid, .cmd_out, .cmd_bank,
    .cmd_mr_addr, .cke, .derate_active, .boot_clock_ok
  );
  lctg_mem_model lctg_mem_model_inst (
    .sys_clk, .sys_rst, .cmd_valid, .cmd_out, .cmd_mr_addr, .temp_load, .temp_val,
    .mr_rdata_valid, .mr_rdata
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int need(input int ps, input int mn);
    int c;
    c = (ps + 49999) / 50000;
    return (c > mn) ? c : mn;
  endfunction : need

  task automatic tally_and_finish;
    if ((n_fail == 0) && (cmp_count > 0)) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Ready is read at the falling edge, settled well before the taking edge
  task automatic issue(input lctg_pkg::lctg_cmd_t c, input logic [2:0] b, input logic [7:0] a,
                       output int tk);
    logic r;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_mr_addr = a;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge sys_clk);
      r = req_ready;
      tk = cyc;
      @(posedge sys_clk);
    end
    #5;
    check("cmd_valid", cmd_valid, 1'b1);
    check("cmd_out", cmd_out, c);
    check("cmd_bank", cmd_bank, b);
    check("cmd_mr_addr", cmd_mr_addr, a);
  endtask : issue

  task automatic idle(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : idle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    check("cmd_valid", cmd_valid, 1'b0);
    check("cmd_out", cmd_out, lctg_pkg::LCTG_CMD_NOP);
    check("cke", cke, 1'b1);
    check("derate", derate_active, 1'b0);
    idle(1);
    check("boot_ok", boot_clock_ok, 1'b1);
  endtask : s_reset

  task automatic s_chain;
    lctg_pkg::lctg_cmd_t sc[13];
    logic [2:0]          sb[13];
    sc = '{lctg_pkg::LCTG_CMD_MRW, lctg_pkg::LCTG_CMD_MRR, lctg_pkg::LCTG_CMD_ACT,
           lctg_pkg::LCTG_CMD_ACT, lctg_pkg::LCTG_CMD_RD, lctg_pkg::LCTG_CMD_PRE,
           lctg_pkg::LCTG_CMD_WR, lctg_pkg::LCTG_CMD_RD, lctg_pkg::LCTG_CMD_SR_ENTER,
           lctg_pkg::LCTG_CMD_SR_EXIT, lctg_pkg::LCTG_CMD_PD_ENTER,
           lctg_pkg::LCTG_CMD_PD_EXIT, lctg_pkg::LCTG_CMD_PRE};
    sb = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    for (int i = 0; i < 13; i++) issue(sc[i], sb[i], 8'h04, t[i]);
    idle(2);
    check("mrw gap", t[1] - t[0], `LCTG_MRW_CYC);
    check("mrr gap", t[2] - t[1], `LCTG_MRR_CYC);
    check("act gap", (t[3] - t[2]) >= need(`LCTG_RRD_PS, `LCTG_RRD_CYC), 1);
    check("rd pre gap", (t[5] - t[4]) >= need(`LCTG_RTP_PS, `LCTG_RTP_CYC), 1);
    check("wr rd gap", (t[7] - t[6]) >= need(`LCTG_WTR_SLOW_PS, `LCTG_WTR_CYC), 1);
    check("sr low", (t[9] - t[8]) >= need(`LCTG_SR_LOW_PS, `LCTG_SR_LOW_CYC), 1);
    check("sr exit", (t[10] - t[9]) >=
          need(`LCTG_RFCAB_PS + `LCTG_SR_EXIT_ADD_PS, `LCTG_SR_EXIT_CYC), 1);
    check("pd exit", (t[12] - t[11]) >= need(`LCTG_PD_EXIT_PS, `LCTG_PD_EXIT_CYC), 1);
  endtask : s_chain

  task automatic s_deep;
    issue(lctg_pkg::LCTG_CMD_DPD_ENTER, 3'h0, 8'h04, t[0]);
    idle(4);
    check("cke deep", cke, 1'b0);
    issue(lctg_pkg::LCTG_CMD_DPD_EXIT, 3'h0, 8'h04, t[1]);
    idle(4);
    check("dpd stay", (t[1] - t[0]) >= 20, 1);
    check("cke woke", cke, 1'b1);
  endtask : s_deep

  task automatic s_derate;
    temp_val = 3'h5;
    temp_load = 1'b1;
    idle(1);
    temp_load = 1'b0;
    issue(lctg_pkg::LCTG_CMD_MRR, 3'h0, `LCTG_TEMP_MR_ADDR, t[0]);
    idle(5);
    check("derate on", derate_active, 1'b1);
    // Reset write sends the temperature code back to its default
    issue(lctg_pkg::LCTG_CMD_MRW, 3'h0, 8'h3F, t[0]);
    issue(lctg_pkg::LCTG_CMD_MRR, 3'h0, `LCTG_TEMP_MR_ADDR, t[1]);
    idle(5);
    check("derate off", derate_active, 1'b0);
  endtask : s_derate

  initial begin
    {n_fail, cmp_count, cyc} = '0;
    {sys_rst, configured, req_valid, temp_load} = 4'h8;
    {req_bank, temp_val} = '0;
    req_cmd = lctg_pkg::LCTG_CMD_NOP;
    req_mr_addr = 8'h00;
    repeat (12) @(posedge sys_clk);
    #5;
    check("boot in reset", boot_clock_ok, 1'b0);
    sys_rst = 1'b0;
    configured = 1'b1;
    idle(1);
    s_reset();
    s_chain();
    s_deep();
    s_derate();
    tally_and_finish();
  end
endmodule : test_lpddr_command_timing_guard

`default_nettype wire
